// >>> ssm_defines.vh
// ssm_defines.vh: offsets, codes and constants of the serial status map.
// assumes nothing; definitions only.
`ifndef SSM_DEFINES_VH
`define SSM_DEFINES_VH

// status map register addresses
`define SSM_OUTPUT_TORQUE_PCT     16'h210B
`define SSM_MOTOR_SPEED_RPM       16'h210C
`define SSM_POWER_OUTPUT_KWH      16'h210F
`define SSM_MULTI_FUNCTION_DISP   16'h2116
`define SSM_SCALED_MAX_VALUE      16'h211B
`define SSM_CURRENT_DECIMAL_POS   16'h211F
`define SSM_DISPLAY_OUT_CURRENT   16'h2200
`define SSM_DISPLAY_COUNTER       16'h2201
`define SSM_ACTUAL_OUT_FREQ       16'h2202
`define SSM_DC_BUS_VOLTAGE        16'h2203
`define SSM_OUTPUT_VOLTAGE        16'h2204
`define SSM_POWER_ANGLE           16'h2205
`define SSM_MOTOR_POWER_KW        16'h2206
`define SSM_ESTIMATED_SPEED_RPM   16'h2207
`define SSM_SIGNED_TORQUE_PCT     16'h2208
`define SSM_PID_FEEDBACK          16'h220A
`define SSM_VOLTAGE_IN_ONE_LEVEL  16'h220B
`define SSM_CURRENT_IN_LEVEL      16'h220C
`define SSM_VOLTAGE_IN_TWO_LEVEL  16'h220D
`define SSM_POWER_MODULE_TEMP     16'h220E
`define SSM_CAPACITOR_TEMP        16'h220F
`define SSM_DIGITAL_INPUT_STATE   16'h2210
`define SSM_DIGITAL_OUTPUT_STATE  16'h2211
`define SSM_ACTIVE_SPEED_STEP     16'h2212
`define SSM_CPU_INPUT_PIN_STATE   16'h2213
`define SSM_CPU_OUTPUT_PIN_STATE  16'h2214
`define SSM_OVERLOAD_COUNTER      16'h2219
`define SSM_GROUND_FAULT_LEVEL    16'h221A
`define SSM_DC_BUS_RIPPLE         16'h221B
`define SSM_LOGIC_REG_MIRROR      16'h221C
`define SSM_USER_PAGE_VALUE       16'h221E
`define SSM_USER_DISPLAY_OUTPUT   16'h221F
`define SSM_MOTOR_REVOLUTIONS     16'h2220
`define SSM_MOTOR_POSITION        16'h2221
`define SSM_FAN_SPEED             16'h2222
`define SSM_CONTROL_MODE          16'h2223
`define SSM_CARRIER_FREQUENCY     16'h2224
`define SSM_DRIVE_STATUS_WORD     16'h2226
`define SSM_ESTIMATED_TORQUE_NM   16'h2227
`define SSM_ENERGY_KWH            16'h2229
`define SSM_PID_REFERENCE         16'h222E
`define SSM_PID_OFFSET            16'h222F
`define SSM_PID_OUTPUT_FREQUENCY  16'h2230
`define SSM_HARDWARE_IDENTIFIER   16'h2231

// function codes
`define SSM_FC_READ_HOLDING       8'h03
`define SSM_FC_EXCEPTION_BIT      8'h80

// exception codes
`define SSM_EXC_NONE              8'h00
`define SSM_EXC_ILLEGAL_FUNCTION  8'h01
`define SSM_EXC_ILLEGAL_ADDRESS   8'h02
`define SSM_EXC_ILLEGAL_DATA      8'h03
`define SSM_EXC_EXEC_FAIL         8'h04
`define SSM_EXC_TIMEOUT           8'h0A

// drive status word fields
`define SSM_DIR_NONE              2'h0
`define SSM_DIR_FORWARD           2'h1
`define SSM_DIR_REVERSE           2'h2
`define SSM_STATE_READY           2'h1
`define SSM_STATE_ERROR           2'h2

// scaling constants
`define SSM_SPEED_MODE            16'h0000
`define SSM_CURRENT_SPLIT         17'h0_FFFF
`define SSM_CURRENT_DEC_TWO       8'h02
`define SSM_CURRENT_DEC_ONE       8'h01
`define SSM_ANALOG_FULL_SCALE     16'h2710

// transfer time limit in microseconds, and cycles at 40 MHz
`define SSM_CLK_MHZ               40
`define SSM_XFER_LIMIT_US         1000
`define SSM_XFER_LIMIT_CYC        (`SSM_XFER_LIMIT_US * `SSM_CLK_MHZ)

`endif

// >>> ssm_status_map.v
// ssm_status_map.v: read-only status map of a drive with the serial
// request decoder and exception answer.
// assumes a frame layer that hands over decoded requests, one per pulse,
// and sends the answer words back to the master.
`timescale 1ns/1ps
`include "ssm_defines.vh"

module ssm_status_map #(
   parameter XFER_LIMIT_CYC = `SSM_XFER_LIMIT_CYC,
   parameter ADC_WIDTH      = 12
) (
   input  wire        CLK,
   input  wire        RESET,
   // request from the frame layer
   input  wire        REQ_VALID,
   input  wire [7:0]  REQ_FUNC,
   input  wire [15:0] REQ_ADDR,
   input  wire [7:0]  REQ_COUNT,
   input  wire        REQ_COMM_ERROR,
   input  wire        REQ_EXEC_FAIL,
   input  wire        XFER_ACTIVE,
   // drive settings
   input  wire [15:0] USER_MAX_VALUE_SETTING,
   input  wire [15:0] MAX_OPERATION_FREQUENCY_SETTING,
   input  wire [15:0] KEYPAD_FREQUENCY_SETTING,
   input  wire [15:0] STORED_SERIAL_FREQUENCY_SETTING,
   input  wire        SOURCE_IS_SERIAL,
   // drive measurements
   input  wire [15:0] OUTPUT_TORQUE_RAW,
   input  wire [15:0] MOTOR_SPEED_RAW,
   input  wire [15:0] POWER_OUTPUT_RAW,
   input  wire [15:0] MULTI_FUNCTION_RAW,
   input  wire [19:0] OUTPUT_CURRENT_CA,
   input  wire [15:0] COUNTER_RAW,
   input  wire [15:0] OUTPUT_FREQ_RAW,
   input  wire [15:0] DC_BUS_RAW,
   input  wire [15:0] OUTPUT_VOLTAGE_RAW,
   input  wire [15:0] POWER_ANGLE_RAW,
   input  wire [15:0] MOTOR_POWER_RAW,
   input  wire [15:0] EST_SPEED_RAW,
   input  wire [15:0] SIGNED_TORQUE_RAW,
   input  wire [15:0] PID_FEEDBACK_RAW,
   input  wire [ADC_WIDTH-1:0] VOLTAGE_INPUT_ONE,
   input  wire [15:0] CURRENT_ANALOG_INPUT,
   input  wire [15:0] VOLTAGE_INPUT_TWO,
   input  wire [15:0] MODULE_TEMP_RAW,
   input  wire [15:0] CAP_TEMP_RAW,
   input  wire [15:0] DIGITAL_IN_RAW,
   input  wire [15:0] DIGITAL_OUT_RAW,
   input  wire [15:0] SPEED_STEP_RAW,
   input  wire [15:0] CPU_IN_RAW,
   input  wire [15:0] CPU_OUT_RAW,
   input  wire [15:0] OVERLOAD_RAW,
   input  wire [15:0] GROUND_FAULT_RAW,
   input  wire [15:0] RIPPLE_RAW,
   input  wire [15:0] LOGIC_MIRROR_RAW,
   input  wire [15:0] USER_PAGE_RAW,
   input  wire [15:0] USER_DISPLAY_RAW,
   input  wire [15:0] REVOLUTIONS_RAW,
   input  wire [15:0] POSITION_RAW,
   input  wire [15:0] FAN_SPEED_RAW,
   input  wire        SPEED_MODE,
   input  wire [15:0] OTHER_MODE_CODE,
   input  wire [15:0] CARRIER_RAW,
   input  wire        DIR_FORWARD,
   input  wire        DIR_REVERSE,
   input  wire        DRIVE_READY,
   input  wire        DRIVE_ERROR,
   input  wire        DRIVE_OUTPUT_ON,
   input  wire        DRIVE_ALARM,
   input  wire [15:0] TORQUE_NM_RAW,
   input  wire [15:0] ENERGY_RAW,
   input  wire [15:0] PID_REF_RAW,
   input  wire [15:0] PID_OFFSET_RAW,
   input  wire [15:0] PID_OUT_RAW,
   input  wire [15:0] HARDWARE_ID_RAW,
   // answer to the frame layer
   output reg         RSP_VALID,
   output reg         RSP_EXCEPTION,
   output reg  [7:0]  RSP_FUNC,
   output reg  [7:0]  RSP_EXC_CODE,
   output reg  [15:0] RSP_DATA,
   // keypad indication
   output reg         COMM_ERROR_INDICATION,
   output reg  [7:0]  COMM_ERROR_SUFFIX
);

   // one-hot states of the answer sequencer
   localparam ST_IDLE = 3'b001;
   localparam ST_CALC = 3'b010;
   localparam ST_RESP = 3'b100;

   reg  [2:0]  state_reg;          // sequencer state
   reg  [2:0]  state_next;
   reg  [7:0]  func_reg;           // latched function code
   reg  [15:0] addr_reg;           // latched start address
   reg  [7:0]  exc_reg;            // latched exception code
   reg  [31:0] xfer_cnt_reg;       // transfer duration counter
   reg         xfer_over_reg;      // transfer overran its limit
   reg  [15:0] scaled_max_reg;     // derived scaled maximum
   reg  [15:0] read_word;          // combinational map read
   reg         addr_ok;            // address is mapped
   reg  [15:0] cur_disp;           // displayed current
   reg  [7:0]  cur_dec;            // decimal places in use
   wire [31:0] scaled_prod;        // frequency times user maximum
   wire [31:0] scaled_quot;        // scaled product over maximum frequency
   wire [15:0] scale_freq;         // frequency picked by source
   wire [31:0] analog_pct;         // first voltage input in 0.01 %
   wire [15:0] status_word;        // packed drive status
   wire [19:0] cur_tenths;         // current in 0.1 A

   // scale a raw level onto 0..10000 (0.00..100.00 %)
   function [31:0] ssm_scale;
      input [31:0] value;
      input [31:0] full;
      begin
         ssm_scale = (value * {16'h0000, `SSM_ANALOG_FULL_SCALE}) / full;
      end
   endfunction

   // full-span input range maps linearly to percent
   assign analog_pct = ssm_scale({{(32-ADC_WIDTH){1'b0}}, VOLTAGE_INPUT_ONE},
                                 (32'h0000_0001 << ADC_WIDTH) - 32'h0000_0001);

   // source select for the scaled maximum
   assign scale_freq  = SOURCE_IS_SERIAL ? STORED_SERIAL_FREQUENCY_SETTING
                                         : KEYPAD_FREQUENCY_SETTING;
   assign scaled_prod = scale_freq * USER_MAX_VALUE_SETTING;
   assign scaled_quot = scaled_prod / {16'h0000, MAX_OPERATION_FREQUENCY_SETTING};

   // direction, readiness, output and alarm fields
   assign status_word = {10'h000, DRIVE_ALARM, DRIVE_OUTPUT_ON,
                         DRIVE_ERROR ? `SSM_STATE_ERROR :
                         (DRIVE_READY ? `SSM_STATE_READY : 2'h0),
                         DIR_FORWARD ? `SSM_DIR_FORWARD :
                         (DIR_REVERSE ? `SSM_DIR_REVERSE : `SSM_DIR_NONE)};

   assign cur_tenths = OUTPUT_CURRENT_CA / 20'h0_000A;

   // current display drops to one decimal above 655.35 A
   always @* begin
      if (OUTPUT_CURRENT_CA > {3'h0, `SSM_CURRENT_SPLIT}) begin
         cur_disp = cur_tenths[15:0];
         cur_dec  = `SSM_CURRENT_DEC_ONE;
      end else begin
         cur_disp = OUTPUT_CURRENT_CA[15:0];
         cur_dec  = `SSM_CURRENT_DEC_TWO;
      end
   end

   // scaled maximum register, refreshed every cycle
   always @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         scaled_max_reg <= 16'h0000;
      end else if (USER_MAX_VALUE_SETTING == 16'h0000) begin
         scaled_max_reg <= MAX_OPERATION_FREQUENCY_SETTING;
      end else if (MAX_OPERATION_FREQUENCY_SETTING == 16'h0000) begin
         scaled_max_reg <= 16'h0000;                             // guard divide by zero
      end else begin
         scaled_max_reg <= (scaled_quot > 32'h0000_FFFF) ? 16'hFFFF : scaled_quot[15:0];
      end
   end

   // address decode of the read-only map
   always @* begin
      addr_ok   = 1'b1;
      read_word = 16'h0000;
      case (addr_reg)
         `SSM_OUTPUT_TORQUE_PCT:    read_word = OUTPUT_TORQUE_RAW;
         `SSM_MOTOR_SPEED_RPM:      read_word = MOTOR_SPEED_RAW;
         `SSM_POWER_OUTPUT_KWH:     read_word = POWER_OUTPUT_RAW;
         `SSM_MULTI_FUNCTION_DISP:  read_word = MULTI_FUNCTION_RAW;
         `SSM_SCALED_MAX_VALUE:     read_word = scaled_max_reg;
         `SSM_CURRENT_DECIMAL_POS:  read_word = {cur_dec, 8'h00};
         `SSM_DISPLAY_OUT_CURRENT:  read_word = cur_disp;
         `SSM_DISPLAY_COUNTER:      read_word = COUNTER_RAW;
         `SSM_ACTUAL_OUT_FREQ:      read_word = OUTPUT_FREQ_RAW;
         `SSM_DC_BUS_VOLTAGE:       read_word = DC_BUS_RAW;
         `SSM_OUTPUT_VOLTAGE:       read_word = OUTPUT_VOLTAGE_RAW;
         `SSM_POWER_ANGLE:          read_word = POWER_ANGLE_RAW;
         `SSM_MOTOR_POWER_KW:       read_word = MOTOR_POWER_RAW;
         `SSM_ESTIMATED_SPEED_RPM:  read_word = EST_SPEED_RAW;
         `SSM_SIGNED_TORQUE_PCT:    read_word = SIGNED_TORQUE_RAW;
         `SSM_PID_FEEDBACK:         read_word = PID_FEEDBACK_RAW;
         `SSM_VOLTAGE_IN_ONE_LEVEL: read_word = analog_pct[15:0];
         `SSM_CURRENT_IN_LEVEL:     read_word = CURRENT_ANALOG_INPUT;
         `SSM_VOLTAGE_IN_TWO_LEVEL: read_word = VOLTAGE_INPUT_TWO;
         `SSM_POWER_MODULE_TEMP:    read_word = MODULE_TEMP_RAW;
         `SSM_CAPACITOR_TEMP:       read_word = CAP_TEMP_RAW;
         `SSM_DIGITAL_INPUT_STATE:  read_word = DIGITAL_IN_RAW;
         `SSM_DIGITAL_OUTPUT_STATE: read_word = DIGITAL_OUT_RAW;
         `SSM_ACTIVE_SPEED_STEP:    read_word = SPEED_STEP_RAW;
         `SSM_CPU_INPUT_PIN_STATE:  read_word = CPU_IN_RAW;
         `SSM_CPU_OUTPUT_PIN_STATE: read_word = CPU_OUT_RAW;
         `SSM_OVERLOAD_COUNTER:     read_word = OVERLOAD_RAW;
         `SSM_GROUND_FAULT_LEVEL:   read_word = GROUND_FAULT_RAW;
         `SSM_DC_BUS_RIPPLE:        read_word = RIPPLE_RAW;
         `SSM_LOGIC_REG_MIRROR:     read_word = LOGIC_MIRROR_RAW;
         `SSM_USER_PAGE_VALUE:      read_word = USER_PAGE_RAW;
         `SSM_USER_DISPLAY_OUTPUT:  read_word = USER_DISPLAY_RAW;
         `SSM_MOTOR_REVOLUTIONS:    read_word = REVOLUTIONS_RAW;
         `SSM_MOTOR_POSITION:       read_word = POSITION_RAW;
         `SSM_FAN_SPEED:            read_word = FAN_SPEED_RAW;
         `SSM_CONTROL_MODE:         read_word = SPEED_MODE ? `SSM_SPEED_MODE
                                                           : OTHER_MODE_CODE;
         `SSM_CARRIER_FREQUENCY:    read_word = CARRIER_RAW;
         `SSM_DRIVE_STATUS_WORD:    read_word = status_word;
         `SSM_ESTIMATED_TORQUE_NM:  read_word = TORQUE_NM_RAW;
         `SSM_ENERGY_KWH:           read_word = ENERGY_RAW;
         `SSM_PID_REFERENCE:        read_word = PID_REF_RAW;
         `SSM_PID_OFFSET:           read_word = PID_OFFSET_RAW;
         `SSM_PID_OUTPUT_FREQUENCY: read_word = PID_OUT_RAW;
         `SSM_HARDWARE_IDENTIFIER:  read_word = HARDWARE_ID_RAW;
         default:                   addr_ok   = 1'b0;                      // unmapped
      endcase
   end

   // transfer duration watchdog
   always @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         xfer_cnt_reg  <= 32'h0000_0000;
         xfer_over_reg <= 1'b0;
      end else if (!XFER_ACTIVE) begin
         // re-armed between transfers
         xfer_cnt_reg  <= 32'h0000_0000;
         xfer_over_reg <= 1'b0;
      end else if (xfer_cnt_reg >= XFER_LIMIT_CYC - 1) begin
         xfer_over_reg <= 1'b1;
      end else begin
         xfer_cnt_reg  <= xfer_cnt_reg + 32'h0000_0001;
      end
   end

   // sequencer next state
   always @* begin
      case (state_reg)
         ST_IDLE: state_next = REQ_VALID ? ST_CALC : ST_IDLE;
         ST_CALC: state_next = ST_RESP;
         ST_RESP: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   // request latch, error classification and answer
   always @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state_reg             <= ST_IDLE;
         func_reg              <= 8'h00;
         addr_reg              <= 16'h0000;
         exc_reg               <= `SSM_EXC_NONE;
         RSP_VALID             <= 1'b0;
         RSP_EXCEPTION         <= 1'b0;
         RSP_FUNC              <= 8'h00;
         RSP_EXC_CODE          <= `SSM_EXC_NONE;
         RSP_DATA              <= 16'h0000;
         COMM_ERROR_INDICATION <= 1'b0;
         COMM_ERROR_SUFFIX     <= 8'h00;
      end else begin
         state_reg <= state_next;
         RSP_VALID <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (REQ_VALID) begin
                  func_reg <= REQ_FUNC;
                  addr_reg <= REQ_ADDR;
                  // priority: timeout, function, data, execution
                  if (xfer_over_reg || REQ_COMM_ERROR) begin
                     exc_reg <= `SSM_EXC_TIMEOUT;
                  end else if (REQ_FUNC != `SSM_FC_READ_HOLDING) begin
                     exc_reg <= `SSM_EXC_ILLEGAL_FUNCTION;
                  end else if (REQ_COUNT != 8'h01) begin
                     exc_reg <= `SSM_EXC_ILLEGAL_DATA;
                  end else if (REQ_EXEC_FAIL) begin
                     exc_reg <= `SSM_EXC_EXEC_FAIL;
                  end else begin
                     exc_reg <= `SSM_EXC_NONE;
                  end
               end
            end
            ST_CALC: begin
               // address check only for a request otherwise good
               if (exc_reg == `SSM_EXC_NONE && !addr_ok) begin
                  exc_reg <= `SSM_EXC_ILLEGAL_ADDRESS;
               end
            end
            ST_RESP: begin
               RSP_VALID <= 1'b1;
               if (exc_reg != `SSM_EXC_NONE) begin
                  // exception replaces the normal answer
                  RSP_EXCEPTION         <= 1'b1;
                  RSP_FUNC              <= func_reg | `SSM_FC_EXCEPTION_BIT;
                  RSP_EXC_CODE          <= exc_reg;
                  RSP_DATA              <= 16'h0000;
                  COMM_ERROR_INDICATION <= 1'b1;
                  COMM_ERROR_SUFFIX     <= exc_reg;
               end else begin
                  RSP_EXCEPTION <= 1'b0;
                  RSP_FUNC      <= func_reg;
                  RSP_EXC_CODE  <= `SSM_EXC_NONE;
                  RSP_DATA      <= read_word;
               end
            end
            default: begin
               exc_reg <= `SSM_EXC_NONE;
            end
         endcase
      end
   end

endmodule

// >>> ssm_master_model.sv
// ssm_master_model.sv: serial master offering requests and collecting answers.
// assumes an answer within eight cycles of the take.
`timescale 1ns/1ps
module ssm_master_model (
   input  wire         CLK,
   output logic        REQ_VALID,
   output logic [7:0]  REQ_FUNC,
   output logic [15:0] REQ_ADDR,
   output logic [7:0]  REQ_COUNT,
   output logic        REQ_COMM_ERROR,
   output logic        REQ_EXEC_FAIL,
   output logic        XFER_ACTIVE,
   input  wire         RSP_VALID,
   input  wire         RSP_EXCEPTION,
   input  wire  [7:0]  RSP_FUNC,
   input  wire  [7:0]  RSP_EXC_CODE,
   input  wire  [15:0] RSP_DATA
);
   logic        got_exc;   // answer was an exception
   logic [7:0]  got_func;  // echoed function
   logic [7:0]  got_code;  // exception code
   logic [15:0] got_data;  // read word
   logic        timed_out; // no answer within the bound

   // idle bus at time zero
   initial begin
      {REQ_VALID, REQ_COMM_ERROR, REQ_EXEC_FAIL, XFER_ACTIVE} = 4'h0;
      {REQ_FUNC, REQ_ADDR, REQ_COUNT} = 32'h0000_0000;
   end

   // one request, optionally inside a frame that runs too long
   task automatic xact(input logic [7:0] f, input logic [15:0] a, input logic [7:0] n,
                       input logic ce, ef, xa);
      int i;
      @(posedge CLK);
      #1;
      XFER_ACTIVE = xa;
      if (xa) begin
         repeat (25) @(posedge CLK);
         #1;
      end
      {REQ_FUNC, REQ_ADDR, REQ_COUNT, REQ_COMM_ERROR, REQ_EXEC_FAIL} = {f, a, n, ce, ef};
      REQ_VALID = 1'b1;
      @(posedge CLK);
      #1;
      REQ_VALID = 1'b0;
      // released fields no longer carry the request
      {REQ_FUNC, REQ_ADDR, REQ_COUNT} = ~{f, a, n};
      for (i = 0; RSP_VALID !== 1'b1 && i < 8; i++) begin
         @(posedge CLK);
         #1;
      end
      timed_out = (i == 8);
      {got_exc, got_func, got_code, got_data} = {RSP_EXCEPTION, RSP_FUNC, RSP_EXC_CODE, RSP_DATA};
      XFER_ACTIVE = 1'b0;
   endtask
endmodule

// >>> ssm_monitor.sv
// ssm_monitor.sv: concurrent checks on the request and answer ports.
// assumes requests are offered as one-cycle pulses on CLK.
`timescale 1ns/1ps
module ssm_monitor (
   input wire        CLK,
   input wire        RESET,
   input wire        REQ_VALID,
   input wire [7:0]  REQ_FUNC,
   input wire [7:0]  REQ_COUNT,
   input wire        REQ_COMM_ERROR,
   input wire        REQ_EXEC_FAIL,
   input wire        XFER_ACTIVE,
   input wire        RSP_VALID,
   input wire        RSP_EXCEPTION,
   input wire [7:0]  RSP_FUNC,
   input wire [7:0]  RSP_EXC_CODE,
   input wire [15:0] RSP_DATA,
   input wire        COMM_ERROR_INDICATION,
   input wire [7:0]  COMM_ERROR_SUFFIX
);
   reg  [1:0] gap_reg;   // cycles in which a new pulse is ignored
   reg        quiet_reg; // frame line was low at the last edge
   wire       take  = REQ_VALID && (gap_reg == 2'h0);
   wire       clean = take && !REQ_COMM_ERROR && !XFER_ACTIVE && quiet_reg;

   // take spacing and frame quiet tracking
   always @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         gap_reg <= 2'h0;
         quiet_reg <= 1'b0;
      end else begin
         gap_reg <= take ? 2'h2 : ((gap_reg == 2'h0) ? 2'h0 : gap_reg - 2'h1);
         quiet_reg <= !XFER_ACTIVE;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   // exception answer three edges after the take
   sequence s_answer(logic [7:0] code);
      ##3 RSP_VALID && RSP_EXCEPTION && (RSP_EXC_CODE == code);
   endsequence
   // one-cycle answer pulse
   sequence s_pulse;
      ##3 RSP_VALID ##1 !RSP_VALID;
   endsequence

   property p_latency;
      take |-> s_pulse;
   endproperty
   a_latency: assert property (p_latency) else $error("answer not three cycles after take");
   property p_no_spurious;
      RSP_VALID |-> $past(take, 3);
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("answer without request");
   property p_comm_err;
      take && REQ_COMM_ERROR |-> s_answer(8'h0A);
   endproperty
   a_comm_err: assert property (p_comm_err) else $error("comm error not code 10");
   property p_echo;
      take |-> ##3 RSP_FUNC == ($past(REQ_FUNC, 3) | {RSP_EXCEPTION, 7'h00});
   endproperty
   a_echo: assert property (p_echo) else $error("function echo wrong");
   property p_bad_func;
      clean && REQ_FUNC != 8'h03 |-> s_answer(8'h01);
   endproperty
   a_bad_func: assert property (p_bad_func) else $error("bad function not code 1");
   property p_bad_count;
      clean && REQ_FUNC == 8'h03 && REQ_COUNT != 8'h01 |-> s_answer(8'h03);
   endproperty
   a_bad_count: assert property (p_bad_count) else $error("bad count not code 3");
   property p_exec_fail;
      clean && REQ_FUNC == 8'h03 && REQ_COUNT == 8'h01 && REQ_EXEC_FAIL |-> s_answer(8'h04);
   endproperty
   a_exec_fail: assert property (p_exec_fail) else $error("exec fail not code 4");
   property p_keypad;
      RSP_VALID && RSP_EXCEPTION |-> COMM_ERROR_INDICATION && COMM_ERROR_SUFFIX == RSP_EXC_CODE;
   endproperty
   a_keypad: assert property (p_keypad) else $error("keypad suffix differs");
   property p_suffix_hold;
      !RSP_VALID |-> $stable(COMM_ERROR_SUFFIX) && $stable(RSP_EXC_CODE);
   endproperty
   a_suffix_hold: assert property (p_suffix_hold) else $error("code moved without answer");
endmodule

bind ssm_status_map ssm_monitor mon (.*);

// >>> ssm_status_map_tb_top.sv
// ssm_status_map_tb_top.sv: self-checking bench of the status map.
// assumes the master model and the monitor compile alongside.
`timescale 1ns/1ps
module ssm_status_map_tb_top;
   logic CLK, RESET, REQ_VALID, REQ_COMM_ERROR, REQ_EXEC_FAIL, XFER_ACTIVE, SOURCE_IS_SERIAL;
   logic SPEED_MODE, DIR_FORWARD, DIR_REVERSE, DRIVE_READY, DRIVE_ERROR, DRIVE_OUTPUT_ON;
   logic DRIVE_ALARM, RSP_VALID, RSP_EXCEPTION, COMM_ERROR_INDICATION;
   logic [7:0]  REQ_FUNC, REQ_COUNT, RSP_FUNC, RSP_EXC_CODE, COMM_ERROR_SUFFIX;
   logic [15:0] REQ_ADDR, USER_MAX_VALUE_SETTING, MAX_OPERATION_FREQUENCY_SETTING, RSP_DATA;
   logic [15:0] KEYPAD_FREQUENCY_SETTING, STORED_SERIAL_FREQUENCY_SETTING, OTHER_MODE_CODE;
   logic [19:0] OUTPUT_CURRENT_CA;
   logic [11:0] VOLTAGE_INPUT_ONE;
   logic [15:0] pat [38]; // distinct word per passthrough register
   wire  [15:0] OUTPUT_TORQUE_RAW = pat[0], MOTOR_SPEED_RAW = pat[1], POWER_OUTPUT_RAW = pat[2],
      MULTI_FUNCTION_RAW = pat[3], COUNTER_RAW = pat[4], OUTPUT_FREQ_RAW = pat[5],
      DC_BUS_RAW = pat[6], OUTPUT_VOLTAGE_RAW = pat[7], POWER_ANGLE_RAW = pat[8],
      MOTOR_POWER_RAW = pat[9], EST_SPEED_RAW = pat[10], SIGNED_TORQUE_RAW = pat[11],
      PID_FEEDBACK_RAW = pat[12], CURRENT_ANALOG_INPUT = pat[13], VOLTAGE_INPUT_TWO = pat[14],
      MODULE_TEMP_RAW = pat[15], CAP_TEMP_RAW = pat[16], DIGITAL_IN_RAW = pat[17],
      DIGITAL_OUT_RAW = pat[18], SPEED_STEP_RAW = pat[19], CPU_IN_RAW = pat[20],
      CPU_OUT_RAW = pat[21], OVERLOAD_RAW = pat[22], GROUND_FAULT_RAW = pat[23],
      RIPPLE_RAW = pat[24], LOGIC_MIRROR_RAW = pat[25], USER_PAGE_RAW = pat[26],
      USER_DISPLAY_RAW = pat[27], REVOLUTIONS_RAW = pat[28], POSITION_RAW = pat[29],
      FAN_SPEED_RAW = pat[30], CARRIER_RAW = pat[31], TORQUE_NM_RAW = pat[32],
      ENERGY_RAW = pat[33], PID_REF_RAW = pat[34], PID_OFFSET_RAW = pat[35],
      PID_OUT_RAW = pat[36], HARDWARE_ID_RAW = pat[37];
   int failures = 0;     // mismatches seen
   int total_checks = 0; // comparisons made

   ssm_status_map #(.XFER_LIMIT_CYC(20)) uut (.*);
   ssm_master_model mst (.*);

   // 40 MHz clock
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end

   task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // request through the master, a lost answer ends the run
   task automatic req(input logic [7:0] f, input logic [15:0] a, input logic [7:0] n,
                      input logic [2:0] fl);
      mst.xact(f, a, n, fl[2], fl[1], fl[0]);
      if (mst.timed_out) begin
         failures++;
         $display("Error answer wait expected pulse seen none");
         conclude();
      end
   endtask

   // single-word read against an expected word
   task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
      req(8'h03, a, 8'h01, 3'h0);
      check(what, {9'h003, 8'h00, exp}, {mst.got_exc, mst.got_func, mst.got_code, mst.got_data});
   endtask

   task automatic t_exceptions();
      logic [11:0] fc [6] = '{12'h001, 12'h002, 12'h003, 12'h204, 12'h40A, 12'h10A}; // flags, code
      for (int k = 0; k < 6; k++) begin
         req(k ? 8'h03 : 8'h06, (k == 1) ? 16'h210D : 16'h2200, (k == 2) ? 8'h02 : 8'h01,
             fc[k][10:8]);
         check("exception func", k ? 8'h83 : 8'h86, mst.got_func);
         check("exception code", fc[k][7:0], mst.got_code);
         check("exception flag", 17'h1_0000, {mst.got_exc, mst.got_data});
         check("keypad", {1'b1, fc[k][7:0]}, {COMM_ERROR_INDICATION, COMM_ERROR_SUFFIX});
      end
   endtask

   task automatic t_derived();
      logic [15:0] pa [38] = '{16'h210B, 16'h210C, 16'h210F, 16'h2116, 16'h2201, 16'h2202,
         16'h2203, 16'h2204, 16'h2205, 16'h2206, 16'h2207, 16'h2208, 16'h220A, 16'h220C,
         16'h220D, 16'h220E, 16'h220F, 16'h2210, 16'h2211, 16'h2212, 16'h2213, 16'h2214,
         16'h2219, 16'h221A, 16'h221B, 16'h221C, 16'h221E, 16'h221F, 16'h2220, 16'h2221,
         16'h2222, 16'h2224, 16'h2227, 16'h2229, 16'h222E, 16'h222F, 16'h2230, 16'h2231};
      for (int k = 0; k < 38; k++) rd(pa[k], 16'hA500 + 16'(k), "passthrough");
      {MAX_OPERATION_FREQUENCY_SETTING, KEYPAD_FREQUENCY_SETTING} = 32'h1770_0BB8;
      STORED_SERIAL_FREQUENCY_SETTING = 16'h04B0;
      rd(16'h211B, 16'h1770, "scaled max user zero");
      USER_MAX_VALUE_SETTING = 16'h0064;
      rd(16'h211B, 16'h0032, "scaled max keypad");
      SOURCE_IS_SERIAL = 1'b1;
      rd(16'h211B, 16'h0014, "scaled max serial");
      OUTPUT_CURRENT_CA = 20'h0_FFFF;
      rd(16'h2200, 16'hFFFF, "current two decimals");
      req(8'h03, 16'h211F, 8'h01, 3'h0);
      check("decimal position two", 8'h02, mst.got_data[15:8]);
      OUTPUT_CURRENT_CA = 20'h1_0000;
      rd(16'h2200, 16'h1999, "current one decimal");
      req(8'h03, 16'h211F, 8'h01, 3'h0);
      check("decimal position one", 8'h01, mst.got_data[15:8]);
      VOLTAGE_INPUT_ONE = 12'hFFF;
      rd(16'h220B, 16'h2710, "voltage input full");
      VOLTAGE_INPUT_ONE = 12'h800;
      rd(16'h220B, 16'h1389, "voltage input half");
      SPEED_MODE = 1'b1;
      rd(16'h2223, 16'h0000, "speed mode");
   endtask

   task automatic t_status();
      int dir;
      logic err, out, alm;
      for (int k = 0; k < 12; k++) begin
         dir = k % 3;
         {err, out, alm} = {1'(k / 3), 1'(k / 6), 1'(k)};
         {DIR_FORWARD, DIR_REVERSE} = {dir == 1, dir == 2};
         {DRIVE_READY, DRIVE_ERROR, DRIVE_OUTPUT_ON, DRIVE_ALARM} = {!err, err, out, alm};
         req(8'h03, 16'h2226, 8'h01, 3'h0);
         check("status word", {alm, out, err, !err, 2'(dir)}, mst.got_data[5:0]);
      end
   endtask

   // reset, then each scenario in turn
   initial begin
      RESET = 1'b1;
      {SOURCE_IS_SERIAL, SPEED_MODE, DIR_FORWARD, DIR_REVERSE, DRIVE_READY} = 5'h00;
      {DRIVE_ERROR, DRIVE_OUTPUT_ON, DRIVE_ALARM, OUTPUT_CURRENT_CA, VOLTAGE_INPUT_ONE} = 35'h0;
      {USER_MAX_VALUE_SETTING, MAX_OPERATION_FREQUENCY_SETTING} = 32'h0000_0000;
      {KEYPAD_FREQUENCY_SETTING, STORED_SERIAL_FREQUENCY_SETTING} = 32'h0000_0000;
      OTHER_MODE_CODE = 16'h0002;
      for (int k = 0; k < 38; k++) pat[k] = 16'hA500 + 16'(k);
      repeat (12) @(posedge CLK);
      #1;
      RESET = 1'b0;
      check("reset outputs", 32'h0, {RSP_VALID, RSP_EXCEPTION, RSP_FUNC, RSP_EXC_CODE, RSP_DATA});
      check("reset keypad", 9'h000, {COMM_ERROR_INDICATION, COMM_ERROR_SUFFIX});
      rd(16'h2223, 16'h0002, "other mode");
      t_exceptions();
      t_derived();
      t_status();
      check("keypad kept", 9'h10A, {COMM_ERROR_INDICATION, COMM_ERROR_SUFFIX});
      conclude();
   end
endmodule
